// ---- rtl/core_ctl_defs.svh ----
// Behaviour
// [R01] Bit 12 selects whether multiply operands are handled as unsigned or signed.
// [R02] Writing one to bit 11 ends the active hardware loop at the end of its current iteration, writing zero does nothing.
// [R03] Read-only bits 10 to 8 give the number of active hardware loops in binary, from 0 up to 7.
// [R04] Bit 7 turns saturation of accumulator A on when set and off when cleared.
// [R05] Bit 5 turns saturation of data-space writes from the signal-processing engine on when set and off when cleared.
// [R06] Bit 2 makes program memory visible in the data address space when set and hides it when cleared.
// [R07] Bit 1 picks biased rounding when set and unbiased convergent rounding when cleared.
// [R08] Bit 0 picks integer multiplies when set and fractional multiplies when cleared.
// [R09] Bits 15 to 13 always read as zero.
// [R10] After reset the low byte is zero except the data-space-write saturation enable, and bit 3 can be read and cleared but never set by software.
// [R11] Bit 3 is the top bit of a 4-bit priority level whose low three bits come from the status register.
// [R12] Writes to the loop depth field and the unused bits are ignored so they show only hardware state.
`ifndef CORE_CTL_DEFS_SVH
`define CORE_CTL_DEFS_SVH

// ==========================================================================
// Register map
`define CORE_CONTROL_OFFSET 8'h44
`define CORE_CONTROL_RESET 16'h0020

// ==========================================================================
// Field positions
`define CC_INT_MODE_POS 0
`define CC_ROUND_SEL_POS 1
`define CC_PROGMEM_VIS_POS 2
`define CC_PRIO_MSB_POS 3
`define CC_ACC_SAT_MODE_POS 4
`define CC_DW_SAT_POS 5
`define CC_ACC_B_SAT_POS 6
`define CC_ACC_A_SAT_POS 7
`define CC_DEPTH_LSB 8
`define CC_DEPTH_MSB 10
`define CC_EARLY_STOP_POS 11
`define CC_UNSIGNED_POS 12

// ==========================================================================
// Loop depth limits
`define LOOP_DEPTH_MAX 3'h7
`define LOOP_DEPTH_NONE 3'h0

`endif

// ---- rtl/core_ctl_pkg.sv ----
package core_ctl_pkg;

  // ==========================================================================
  // Datapath configuration carried to the signal-processing engine.
  typedef struct packed {
    logic mul_unsigned_sel;
    logic acc_a_sat_en;
    logic acc_b_sat_en;
    logic dspace_write_sat_en;
    logic acc_sat_mode;
    logic progmem_visible_en;
    logic round_mode_sel;
    logic int_mode_sel;
  } dsp_cfg_t;

  // ==========================================================================
  // Loop sequencer events, one-cycle pulses from the core.
  typedef struct packed {
    logic loop_start;
    logic loop_end;
    logic iter_end;
  } loop_evt_t;

endpackage

// ---- rtl/loop_depth_tracker.sv ----
`timescale 1ns/10ps
`include "core_ctl_defs.svh"

module loop_depth_tracker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Nesting events
  input wire logic push_i,
  input wire logic pop_i,
  // Depth
  output logic [2:0] depth_o
);

  logic [2:0] depth;
  logic [2:0] next_depth;

  // ==========================================================================
  // Depth counter
  // A push at full depth is dropped, since the field cannot show an eighth loop.
  always_comb begin
    next_depth = depth;
    if (push_i && !pop_i && depth != `LOOP_DEPTH_MAX) begin
      next_depth = depth + 3'h1; // [R03]
    end else if (pop_i && !push_i && depth != `LOOP_DEPTH_NONE) begin
      next_depth = depth - 3'h1; // [R03]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      depth <= `LOOP_DEPTH_NONE;
    end else begin
      depth <= next_depth;
    end
  end

  assign depth_o = depth;

endmodule // loop_depth_tracker

// ---- rtl/core_control_reg.sv ----
// Local design decisions: the register offset and the plain strobed port.
`timescale 1ns/10ps
`include "core_ctl_defs.svh"

module core_control_reg
  import core_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  // Loop sequencer
  input wire loop_evt_t loop_evt_i,
  output logic loop_stop_o,
  output logic [2:0] loop_nest_depth_o,
  // Priority level
  input wire logic [2:0] prio_level_low_i,
  input wire logic prio_msb_set_i,
  output logic [3:0] prio_level_o,
  // Datapath configuration
  output dsp_cfg_t dsp_cfg_o
);

  // ==========================================================================
  // State
  dsp_cfg_t cfg;
  dsp_cfg_t next_cfg;
  logic early_stop_pend;
  logic next_early_stop_pend;
  logic prio_level_msb;
  logic next_prio_level_msb;
  logic loop_stop;
  logic next_loop_stop;
  logic [3:0] prio_level;
  logic [3:0] next_prio_level;
  logic [15:0] rd_data;
  logic [15:0] next_rd_data;
  logic [2:0] loop_nest_depth;
  logic hit;
  logic reg_wr;
  logic reg_rd;
  logic stop_fire;
  logic depth_pop;
  logic [15:0] reg_view;

  // The reset word is mapped field by field, because the struct order is not the register's bit order.
  localparam logic [15:0] RESET_WORD = `CORE_CONTROL_RESET;
  localparam dsp_cfg_t CFG_RESET = '{
    RESET_WORD[`CC_UNSIGNED_POS],
    RESET_WORD[`CC_ACC_A_SAT_POS],
    RESET_WORD[`CC_ACC_B_SAT_POS],
    RESET_WORD[`CC_DW_SAT_POS],
    RESET_WORD[`CC_ACC_SAT_MODE_POS],
    RESET_WORD[`CC_PROGMEM_VIS_POS],
    RESET_WORD[`CC_ROUND_SEL_POS],
    RESET_WORD[`CC_INT_MODE_POS]
  };

  assign hit = (addr_i == `CORE_CONTROL_OFFSET);
  assign reg_wr = wr_i && hit;
  assign reg_rd = rd_i && hit;

  // ==========================================================================
  // Loop nesting
  // The stop fires only on a real iteration boundary of a live loop.
  assign stop_fire = early_stop_pend && loop_evt_i.iter_end && (loop_nest_depth != `LOOP_DEPTH_NONE); // [R02]
  assign depth_pop = loop_evt_i.loop_end || stop_fire; // [R02]

  loop_depth_tracker u_depth (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .push_i(loop_evt_i.loop_start),
    .pop_i(depth_pop),
    .depth_o(loop_nest_depth)
  );

  // ==========================================================================
  // Read view of the register
  always_comb begin
    reg_view = 16'h0000; // [R09]
    reg_view[`CC_UNSIGNED_POS] = cfg.mul_unsigned_sel;
    reg_view[`CC_EARLY_STOP_POS] = early_stop_pend;
    reg_view[`CC_DEPTH_MSB:`CC_DEPTH_LSB] = loop_nest_depth; // [R03]
    reg_view[`CC_ACC_A_SAT_POS] = cfg.acc_a_sat_en;
    reg_view[`CC_ACC_B_SAT_POS] = cfg.acc_b_sat_en;
    reg_view[`CC_DW_SAT_POS] = cfg.dspace_write_sat_en;
    reg_view[`CC_ACC_SAT_MODE_POS] = cfg.acc_sat_mode;
    reg_view[`CC_PRIO_MSB_POS] = prio_level_msb; // [R11]
    reg_view[`CC_PROGMEM_VIS_POS] = cfg.progmem_visible_en;
    reg_view[`CC_ROUND_SEL_POS] = cfg.round_mode_sel;
    reg_view[`CC_INT_MODE_POS] = cfg.int_mode_sel;
  end

  // ==========================================================================
  // Next values
  always_comb begin
    next_cfg = cfg;
    next_early_stop_pend = early_stop_pend;
    next_prio_level_msb = prio_level_msb;
    if (reg_wr) begin
      // Depth and bits 15 to 13 are not taken from the write.
      next_cfg.mul_unsigned_sel = wr_data_i[`CC_UNSIGNED_POS]; // [R01] [R12]
      next_cfg.acc_a_sat_en = wr_data_i[`CC_ACC_A_SAT_POS]; // [R04]
      next_cfg.acc_b_sat_en = wr_data_i[`CC_ACC_B_SAT_POS];
      next_cfg.dspace_write_sat_en = wr_data_i[`CC_DW_SAT_POS]; // [R05]
      next_cfg.acc_sat_mode = wr_data_i[`CC_ACC_SAT_MODE_POS];
      next_cfg.progmem_visible_en = wr_data_i[`CC_PROGMEM_VIS_POS]; // [R06]
      next_cfg.round_mode_sel = wr_data_i[`CC_ROUND_SEL_POS]; // [R07]
      next_cfg.int_mode_sel = wr_data_i[`CC_INT_MODE_POS]; // [R08]
    end
    // Pending stop clears when it fires or no loop is left; a new request wins.
    if (stop_fire || loop_nest_depth == `LOOP_DEPTH_NONE) begin
      next_early_stop_pend = 1'b0;
    end
    if (reg_wr && wr_data_i[`CC_EARLY_STOP_POS] && loop_nest_depth != `LOOP_DEPTH_NONE) begin
      next_early_stop_pend = 1'b1; // [R02]
    end
    // Software may only clear the priority top bit; a hardware set wins.
    if (reg_wr && !wr_data_i[`CC_PRIO_MSB_POS]) begin
      next_prio_level_msb = 1'b0; // [R10]
    end
    if (prio_msb_set_i) begin
      next_prio_level_msb = 1'b1; // [R10]
    end
    next_loop_stop = stop_fire; // [R02]
    next_prio_level = {next_prio_level_msb, prio_level_low_i}; // [R11]
    next_rd_data = reg_rd ? reg_view : 16'h0000;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg <= CFG_RESET; // [R10]
      early_stop_pend <= 1'b0;
      prio_level_msb <= 1'b0; // [R10]
      loop_stop <= 1'b0;
      prio_level <= 4'h0;
      rd_data <= 16'h0000;
    end else begin
      cfg <= next_cfg;
      early_stop_pend <= next_early_stop_pend;
      prio_level_msb <= next_prio_level_msb;
      loop_stop <= next_loop_stop;
      prio_level <= next_prio_level;
      rd_data <= next_rd_data;
    end
  end

  assign dsp_cfg_o = cfg;
  assign loop_stop_o = loop_stop;
  assign loop_nest_depth_o = loop_nest_depth;
  assign prio_level_o = prio_level;
  assign rd_data_o = rd_data;

  // ==========================================================================
  // Assertions
  a_unsigned_sel_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr |=> dsp_cfg_o.mul_unsigned_sel == $past(wr_data_i[`CC_UNSIGNED_POS])) // [R01]
    else $error("Multiply signedness did not follow the write.");

  a_stop_on_iteration: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (early_stop_pend && loop_evt_i.iter_end && loop_nest_depth_o != 3'h0) |=> loop_stop_o) // [R02]
    else $error("Pending early stop did not end the loop.");

  a_stop_needs_request: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    loop_stop_o |-> $past(early_stop_pend) && $past(loop_evt_i.iter_end)) // [R02]
    else $error("Loop stop without request and iteration end.");

  a_zero_write_no_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reg_wr && !wr_data_i[`CC_EARLY_STOP_POS] && !early_stop_pend) |=> !early_stop_pend) // [R02]
    else $error("Writing zero raised an early stop.");

  a_stop_drops_depth: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (stop_fire && !loop_evt_i.loop_start) |=> loop_nest_depth_o == $past(loop_nest_depth_o) - 3'h1) // [R03]
    else $error("Early stop did not reduce the loop depth.");

  a_depth_push: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (loop_evt_i.loop_start && !depth_pop && loop_nest_depth_o != 3'h7)
      |=> loop_nest_depth_o == $past(loop_nest_depth_o) + 3'h1) // [R03]
    else $error("Loop start did not raise the loop depth.");

  a_depth_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_rd |=> rd_data_o[10:8] == $past(loop_nest_depth_o)) // [R03]
    else $error("Read data do not show the loop depth.");

  a_acc_a_sat: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr ##1 !reg_wr |=> dsp_cfg_o.acc_a_sat_en == $past(wr_data_i[`CC_ACC_A_SAT_POS], 2)) // [R04]
    else $error("Accumulator A saturation enable lost its written value.");

  a_dw_sat_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr |=> dsp_cfg_o.dspace_write_sat_en == $past(wr_data_i[`CC_DW_SAT_POS])) // [R05]
    else $error("Data-space write saturation did not follow the write.");

  a_progmem_vis: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr |=> dsp_cfg_o.progmem_visible_en == $past(wr_data_i[`CC_PROGMEM_VIS_POS])) // [R06]
    else $error("Program memory visibility did not follow the write.");

  a_round_sel: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr |=> dsp_cfg_o.round_mode_sel == $past(wr_data_i[`CC_ROUND_SEL_POS])) // [R07]
    else $error("Rounding mode did not follow the write.");

  a_int_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !reg_wr |=> $stable(dsp_cfg_o.int_mode_sel)) // [R08]
    else $error("Multiplier mode changed without a write.");

  a_top_bits_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_data_o[15:13] == 3'h0) // [R09]
    else $error("Unimplemented bits read as nonzero.");

  a_reset_values: assert property (@(posedge clk_i)
    !reset_n_i |=> dsp_cfg_o == 8'h10 && prio_level_o == 4'h0 && !loop_stop_o) // [R10]
    else $error("Reset values are wrong.");

  a_msb_not_settable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!prio_level_msb && !prio_msb_set_i) |=> !prio_level_msb) // [R10]
    else $error("Priority top bit was set by software.");

  a_msb_set_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prio_msb_set_i |=> prio_level_msb && prio_level_o[3]) // [R10]
    else $error("Hardware set of the priority top bit was lost.");

  a_msb_sw_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reg_wr && !wr_data_i[`CC_PRIO_MSB_POS] && !prio_msb_set_i) |=> !prio_level_msb) // [R10]
    else $error("Software clear of the priority top bit was lost.");

  a_stop_idle_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reg_wr && wr_data_i[`CC_EARLY_STOP_POS] && loop_nest_depth_o == 3'h0) |=> !early_stop_pend) // [R02]
    else $error("Early stop was held with no loop active.");

  a_depth_pop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (loop_evt_i.loop_end && !loop_evt_i.loop_start && loop_nest_depth_o != 3'h0)
      |=> loop_nest_depth_o == $past(loop_nest_depth_o) - 3'h1) // [R03]
    else $error("Loop end did not lower the loop depth.");

  a_prio_join: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> prio_level_o == {prio_level_msb, $past(prio_level_low_i)}) // [R11]
    else $error("Priority level is not the joined value.");

  a_depth_not_written: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reg_wr && !loop_evt_i.loop_start && !depth_pop) |=> $stable(loop_nest_depth_o)) // [R12]
    else $error("A write altered the loop depth.");

endmodule // core_control_reg

// ---- tb/tb_core_control_reg.sv ----
`timescale 1ns/10ps
`include "core_ctl_defs.svh"

module tb_core_control_reg;
  import core_ctl_pkg::*;

  // ==========================================================================
  // Stimulus and observation
  logic clk_i;
  logic reset_n_i;
  logic [7:0] addr_i;
  logic [15:0] wr_data_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rd_data_o;
  loop_evt_t loop_evt_i;
  logic loop_stop_o;
  logic [2:0] loop_nest_depth_o;
  logic [2:0] prio_level_low_i;
  logic prio_msb_set_i;
  logic [3:0] prio_level_o;
  dsp_cfg_t dsp_cfg_o;
  int err_count;
  int n_compared;

  core_control_reg i_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .loop_evt_i(loop_evt_i),
    .loop_stop_o(loop_stop_o),
    .loop_nest_depth_o(loop_nest_depth_o),
    .prio_level_low_i(prio_level_low_i),
    .prio_msb_set_i(prio_msb_set_i),
    .prio_level_o(prio_level_o),
    .dsp_cfg_o(dsp_cfg_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rd_data_o, exp);
  endtask

  task automatic loop_pulse(input loop_evt_t e);
    @(posedge clk_i);
    loop_evt_i <= e;
    @(posedge clk_i);
    loop_evt_i <= '0;
    #1;
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0020);
    chk({8'h00, dsp_cfg_o}, 16'h0010);
    chk({12'h000, prio_level_o}, 16'h0000);
    chk({13'h0000, loop_nest_depth_o}, 16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_fields();
    reg_wr(`CORE_CONTROL_OFFSET, 16'hffff);
    chk({8'h00, dsp_cfg_o}, 16'h00ff);
    chk({15'h0000, loop_stop_o}, 16'h0000);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h10f7);
    reg_wr(8'h46, 16'h0000);
    chk({8'h00, dsp_cfg_o}, 16'h00ff);
    reg_rd(8'h46, 16'h0000);
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0000);
    chk({8'h00, dsp_cfg_o}, 16'h0000);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0000);
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0020);
    $display("test_fields done");
  endtask

  task automatic test_depth();
    for (int i = 1; i <= 8; i++) begin
      loop_pulse(3'b100);
      chk({13'h0000, loop_nest_depth_o}, (i > 7) ? 16'h0007 : 16'(i));
    end
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0020);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0720);
    for (int i = 6; i >= 0; i--) begin
      loop_pulse(3'b010);
      chk({13'h0000, loop_nest_depth_o}, 16'(i));
    end
    $display("test_depth done");
  endtask

  task automatic test_early_stop();
    loop_pulse(3'b100);
    loop_pulse(3'b100);
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0820);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0a20);
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0020);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0a20);
    chk({15'h0000, loop_stop_o}, 16'h0000);
    loop_pulse(3'b001);
    chk({15'h0000, loop_stop_o}, 16'h0001);
    chk({13'h0000, loop_nest_depth_o}, 16'h0001);
    @(posedge clk_i);
    #1;
    chk({15'h0000, loop_stop_o}, 16'h0000);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0120);
    loop_pulse(3'b010);
    $display("test_early_stop done");
  endtask

  task automatic test_priority();
    @(posedge clk_i);
    prio_level_low_i <= 3'h5;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    chk({12'h000, prio_level_o}, 16'h0005);
    @(posedge clk_i);
    prio_msb_set_i <= 1'b1;
    @(posedge clk_i);
    prio_msb_set_i <= 1'b0;
    #1;
    chk({12'h000, prio_level_o}, 16'h000d);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0028);
    reg_wr(`CORE_CONTROL_OFFSET, 16'h0020);
    chk({12'h000, prio_level_o}, 16'h0005);
    reg_rd(`CORE_CONTROL_OFFSET, 16'h0020);
    $display("test_priority done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    err_count = 0;
    n_compared = 0;
    reset_n_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    loop_evt_i = '0;
    prio_level_low_i = 3'h0;
    prio_msb_set_i = 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_fields();
    test_depth();
    test_early_stop();
    test_priority();
    end_of_test();
  end

  // A hung sequence is cut short here so the run always reaches the verdict.
  initial begin
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk_i);
    end
    err_count++;
    end_of_test();
  end

endmodule // tb_core_control_reg
